//--- ccl_pkg.sv
// package: register map, field layout and shared types for the comparator control logic
package ccl_pkg;
  // ****************************************************************
  // counts and widths
  // ****************************************************************
  localparam int NUM_CMP = 3;
  localparam int ADR_W = 4;
  // ****************************************************************
  // register byte offsets (word aligned)
  // ****************************************************************
  localparam logic [3:0] OFF_CTRL1 = 4'h0;
  localparam logic [3:0] OFF_CTRL2 = 4'h4;
  localparam logic [3:0] OFF_CTRL3 = 4'h8;
  localparam logic [3:0] OFF_RESULTS = 4'hc;
  localparam logic [3:0] OFF_EVT_FLAG = 4'h0;
  localparam logic [3:0] OFF_EVT_MASK = 4'h4;
  localparam logic [4:0] OFF_HI_FLAG = 5'h10;
  localparam logic [4:0] OFF_HI_MASK = 5'h14;
  // ****************************************************************
  // control field positions
  // ****************************************************************
  localparam int BIT_ENABLE = 7;
  localparam int BIT_PIN_EN = 6;
  localparam int BIT_INVERT = 5;
  localparam int BIT_EDGE_HI = 4;
  localparam int BIT_EDGE_LO = 3;
  localparam int BIT_PLUS_REF = 2;
  localparam int BIT_MINUS_HI = 1;
  localparam int BIT_MINUS_LO = 0;
  localparam int BIT_RESULT_BASE = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [1:0] MINUS_PIN_B = 2'h0;
  localparam logic [1:0] MINUS_PIN_C = 2'h1;
  localparam logic [1:0] MINUS_SHARED = 2'h2;
  localparam logic [1:0] MINUS_BANDGAP = 2'h3;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic comparator_enable;
    logic output_pin_enable;
    logic output_invert;
    logic [1:0] event_edge_select;
    logic plus_input_ref_select;
    logic [1:0] minus_input_select;
  } ccl_ctrl_t;
  // analog select per comparator, toward the analog core
  typedef struct packed {
    logic enable;
    logic plus_ref;
    logic [1:0] minus_sel;
  } ccl_ana_t;
  typedef enum logic [1:0] {
    CCL_IDLE = 2'b01,
    CCL_ACK = 2'b10
  } ccl_bus_state_t;
endpackage : ccl_pkg

//--- ccl_chan.sv
// one comparator channel: sync, polarity, edge detect and event flag
`timescale 1ns/1ps
module ccl_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire ccl_pkg::ccl_ctrl_t ctrl_i,
  input wire logic cfg_any_i,
  // raw analog result and flag control
  input wire logic raw_i,
  input wire logic clr_i,
  input wire logic set_i,
  // results
  output logic result_o,
  output logic flag_o
);
  logic sync_a;
  logic sync_b;
  logic prev;
  logic adj;
  logic rise;
  logic fall;
  logic hit;

  // two-stage synchroniser on the asynchronous comparator output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  // polarity after sync; a disabled comparator reads low before inversion
  assign adj = (sync_b & ctrl_i.comparator_enable) ^ ctrl_i.output_invert;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= adj;
    end
  end

  assign rise = adj & ~prev;
  assign fall = ~adj & prev;

  // edge matching per selected code
  always_comb begin
    case (ctrl_i.event_edge_select)
      ccl_pkg::EDGE_RISE: hit = rise;
      ccl_pkg::EDGE_FALL: hit = fall;
      ccl_pkg::EDGE_ANY: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  // sticky flag: any set beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (hit || set_i || cfg_any_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

  assign result_o = adj;

  edge_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (hit |=> flag_o)) else $error("edge did not set flag");
  off_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.event_edge_select == ccl_pkg::EDGE_OFF && !set_i && !cfg_any_i && !flag_o |=> !flag_o))
    else $error("flag rose with events off");
  // a clear with no competing set must drop the flag
  clr_drops_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clr_i && !hit && !set_i && !cfg_any_i |=> !flag_o)) else $error("clear ignored");
  sim_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (set_i |=> flag_o)) else $error("software set ignored");
endmodule : ccl_chan

//--- ccl_top.sv
// comparator control logic: wishbone registers, input selects, pins, events
`timescale 1ns/1ps
module ccl_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // analog cores
  input wire logic [2:0] raw_result_i,
  output ccl_pkg::ccl_ana_t [2:0] ana_sel_o,
  output logic [2:0] minus_shared_d_o,
  // output pins: port direction bits come in, low output enable drives
  input wire logic [2:0] pin_dir_out_i,
  input wire logic [2:0] port_data_i,
  output logic [2:0] pin_o,
  output logic [2:0] pin_oe_n_o,
  // interrupt
  output logic irq_o
);
  // ****************************************************************
  // register state
  // ****************************************************************
  ccl_pkg::ccl_ctrl_t ctrl [3];
  logic [2:0] mask;
  logic [2:0] result;
  logic [2:0] flag;
  logic [2:0] cfg_any;
  logic [2:0] flag_sim;
  logic [2:0] flag_clr;
  ccl_pkg::ccl_bus_state_t state;
  logic req;
  logic wr;
  logic [7:0] wbyte;

  assign req = cyc_i & stb_i & (state == ccl_pkg::CCL_IDLE);
  assign wr = req & we_i & sel_i[0];
  assign wbyte = dat_i[7:0];

  // ****************************************************************
  // bus handshake: ack one cycle after a request, dropped the next
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ccl_pkg::CCL_IDLE;
    end else begin
      case (state)
        ccl_pkg::CCL_IDLE: if (cyc_i && stb_i) state <= ccl_pkg::CCL_ACK;
        ccl_pkg::CCL_ACK: state <= ccl_pkg::CCL_IDLE;
        default: state <= ccl_pkg::CCL_IDLE;
      endcase
    end
  end
  assign ack_o = (state == ccl_pkg::CCL_ACK);

  // ****************************************************************
  // control registers, one per channel
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < ccl_pkg::NUM_CMP; g++) begin : g_chan
      localparam logic [4:0] OFF = {1'b0, 4'(g * 4)};
      logic hit_ctrl;
      assign hit_ctrl = wr && adr_i == OFF;
      // independent per-channel register
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctrl[g] <= ccl_pkg::CTRL_RESET;
          cfg_any[g] <= 1'b0;
        end else begin
          cfg_any[g] <= 1'b0;
          if (hit_ctrl) begin
            ctrl[g] <= wbyte;
            cfg_any[g] <= (wbyte[ccl_pkg::BIT_EDGE_HI:ccl_pkg::BIT_EDGE_LO] == ccl_pkg::EDGE_ANY);
          end
        end
      end
      assign flag_clr[g] = wr && adr_i == ccl_pkg::OFF_HI_FLAG && wbyte[g];
      ccl_chan u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl_i(ctrl[g]),
        .cfg_any_i(cfg_any[g]),
        .raw_i(raw_result_i[g]),
        .clr_i(flag_clr[g]),
        .set_i(flag_sim[g]),
        .result_o(result[g]),
        .flag_o(flag[g])
      );
      // analog selects; small package forbids codes that need missing pins
      always_comb begin
        ana_sel_o[g].enable = ctrl[g].comparator_enable;
        ana_sel_o[g].plus_ref = ctrl[g].plus_input_ref_select;
        ana_sel_o[g].minus_sel = ctrl[g].minus_input_select;
        if (SMALL_PKG && g != 2 && ctrl[g].minus_input_select == ccl_pkg::MINUS_PIN_C) begin
          ana_sel_o[g].enable = 1'b0;
        end
        if (SMALL_PKG && g == 1 && ctrl[g].minus_input_select == ccl_pkg::MINUS_SHARED) begin
          ana_sel_o[g].enable = 1'b0;
        end
      end
      // shared code: channel two uses pin d, others shared pin b
      assign minus_shared_d_o[g] = (g == 1) && ctrl[g].minus_input_select == ccl_pkg::MINUS_SHARED;
      // pin mux: direction bit still decides the driver
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_o[g] <= 1'b0;
        end else begin
          pin_o[g] <= ctrl[g].output_pin_enable ? result[g] : port_data_i[g];
        end
      end
      assign pin_oe_n_o[g] = ~pin_dir_out_i[g];
    end
  endgenerate

  // ****************************************************************
  // software set of flags: write one to the set register
  // ****************************************************************
  assign flag_sim = (wr && adr_i == ccl_pkg::OFF_HI_MASK + 5'h4) ? wbyte[2:0] : 3'h0;

  // ****************************************************************
  // interrupt mask
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= ccl_pkg::FLAG_RESET;
    end else if (wr && adr_i == ccl_pkg::OFF_HI_MASK) begin
      mask <= wbyte[2:0];
    end
  end
  assign irq_o = |(flag & mask);

  // ****************************************************************
  // read data, registered with the ack
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req) begin
      case (adr_i)
        {1'b0, ccl_pkg::OFF_CTRL1}: dat_o <= {24'h0, ctrl[0]};
        {1'b0, ccl_pkg::OFF_CTRL2}: dat_o <= {24'h0, ctrl[1]};
        {1'b0, ccl_pkg::OFF_CTRL3}: dat_o <= {24'h0, ctrl[2]};
        {1'b0, ccl_pkg::OFF_RESULTS}: dat_o <= {24'h0, result, 5'h00};
        ccl_pkg::OFF_HI_FLAG: dat_o <= {29'h0, flag};
        ccl_pkg::OFF_HI_MASK: dat_o <= {29'h0, mask};
        default: dat_o <= 32'h0;
      endcase
    end
  end

  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o |=> !ack_o)) else $error("ack held two cycles");
  any_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == 5'h00 && wbyte[4:3] == 2'h3 |-> ##2 flag[0])) else $error("any code did not set flag");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_o == |(flag & mask))) else $error("irq mismatch");

  // ****************************************************************
  // bus and register checks
  // ****************************************************************
  // a request taken in idle, answered on the next edge
  sequence s_req_taken;
    cyc_i && stb_i && state == ccl_pkg::CCL_IDLE;
  endsequence
  // a status read taken by the bus
  sequence s_res_read;
    req && !we_i && adr_i == {1'b0, ccl_pkg::OFF_RESULTS};
  endsequence
  // a software set of the first flag
  sequence s_sim_first;
    wr && adr_i == ccl_pkg::OFF_HI_MASK + 5'h4 && wbyte[0];
  endsequence

  ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_req_taken |=> ack_o)) else $error("ack not one cycle after request");
  res_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_res_read |=> dat_o[7:0] == {$past(result), 5'h00})) else $error("results read wrong");
  sim_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_sim_first |=> flag[0])) else $error("software set lost");
  pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[0].output_pin_enable |=> pin_o[0] == $past(result[0]))) else $error("pin not routed");
  pin_drv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_oe_n_o == ~pin_dir_out_i)) else $error("driver enable wrong");
  core_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl[1].comparator_enable |-> !ana_sel_o[1].enable)) else $error("core on while disabled");
endmodule : ccl_top

//--- ccl_ana_model.sv
// behavioural analog comparator cores with their input multiplexers
`timescale 1ns/1ps
module ccl_ana_model (
  // selects from the block
  input wire ccl_pkg::ccl_ana_t [2:0] ana_sel_i,
  input wire logic [2:0] minus_shared_d_i,
  // analog levels as plain unsigned codes
  input wire logic [7:0] plus_lvl_i [3],
  input wire logic [7:0] pin_b_lvl_i [3],
  input wire logic [7:0] ref_lvl_i,
  input wire logic [7:0] shared_b_lvl_i,
  input wire logic [7:0] shared_d_lvl_i,
  input wire logic [7:0] bandgap_lvl_i,
  // raw results toward the block
  output logic [2:0] raw_o
);
  logic [7:0] plus_lvl [3];
  logic [7:0] minus_lvl [3];
  // ideal cores; pin c sits at mid scale since no scenario drives it
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      plus_lvl[k] = ana_sel_i[k].plus_ref ? ref_lvl_i : plus_lvl_i[k];
      case (ana_sel_i[k].minus_sel)
        ccl_pkg::MINUS_PIN_B: minus_lvl[k] = pin_b_lvl_i[k];
        ccl_pkg::MINUS_PIN_C: minus_lvl[k] = 8'h80;
        ccl_pkg::MINUS_SHARED: minus_lvl[k] = minus_shared_d_i[k] ? shared_d_lvl_i : shared_b_lvl_i;
        default: minus_lvl[k] = bandgap_lvl_i;
      endcase
      raw_o[k] = ana_sel_i[k].enable && (plus_lvl[k] > minus_lvl[k]);
    end
  end
endmodule : ccl_ana_model

//--- ccl_top_tb_top.sv
// self-checking bench for the comparator control logic
`timescale 1ns/1ps
module ccl_top_tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [4:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [2:0] raw, minus_shared_d_o, pin_dir_out_i, port_data_i, pin_o, pin_oe_n_o;
  ccl_pkg::ccl_ana_t [2:0] ana_sel_o;
  ccl_pkg::ccl_ana_t [2:0] ana_small;
  logic [7:0] plus_lvl [3];
  logic [7:0] pin_b_lvl [3];
  logic [7:0] ref_lvl, shb_lvl, shd_lvl, bg_lvl;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
  // block under test and its analog far side
  ccl_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .raw_result_i(raw), .ana_sel_o(ana_sel_o),
    .minus_shared_d_o(minus_shared_d_o), .pin_dir_out_i(pin_dir_out_i), .port_data_i(port_data_i),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .irq_o(irq_o));
  // small package variant on the same bus, only its analog selects are watched
  ccl_top #(.SMALL_PKG(1'b1)) i_small (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(), .ack_o(), .raw_result_i(raw), .ana_sel_o(ana_small),
    .minus_shared_d_o(), .pin_dir_out_i(pin_dir_out_i), .port_data_i(port_data_i), .pin_o(), .pin_oe_n_o(),
    .irq_o());
  ccl_ana_model i_ana (.ana_sel_i(ana_sel_o), .minus_shared_d_i(minus_shared_d_o), .plus_lvl_i(plus_lvl),
    .pin_b_lvl_i(pin_b_lvl), .ref_lvl_i(ref_lvl), .shared_b_lvl_i(shb_lvl), .shared_d_lvl_i(shd_lvl),
    .bandgap_lvl_i(bg_lvl), .raw_o(raw));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    if (ack_o !== 1'b1) error_cnt++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    `CHK(rd, exp)
  endtask : rchk
  task automatic t_reset();
    for (int a = 0; a < 6; a++) begin
      rchk(5'(a * 4), 32'h0);
    end
    rchk(5'h1c, 32'h0);
    `CHK(irq_o, 1'b0)
  endtask : t_reset
  task automatic t_select();
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 4; c++) begin
        wb(5'(k * 4), 1'b1, 32'h84 | c);
        rchk(5'(k * 4), 32'h84 | c);
        `CHK(ana_sel_o[k], {1'b1, 1'b1, 2'(c)})
        `CHK(minus_shared_d_o[k], k == 1 && c == 2)
        `CHK(ana_small[k].enable, !((k != 2 && c == 1) || (k == 1 && c == 2)))
      end
      wb(5'(k * 4), 1'b1, 32'h0);
      `CHK(ana_sel_o[k].enable, 1'b0)
    end
  endtask : t_select
  task automatic t_results();
    plus_lvl <= '{8'hc8, 8'h32, 8'hc8};
    shb_lvl <= 8'h0a;
    shd_lvl <= 8'hfa;
    wb(5'h00, 1'b1, 32'h82);
    wb(5'h04, 1'b1, 32'h82);
    wb(5'h08, 1'b1, 32'h80);
    repeat (4) @(posedge clk_i);
    rchk(5'h0c, 32'ha0);
    wb(5'h0c, 1'b1, 32'hff);
    rchk(5'h0c, 32'ha0);
    wb(5'h00, 1'b1, 32'ha2);
    wb(5'h04, 1'b1, 32'ha2);
    wb(5'h08, 1'b1, 32'ha0);
    repeat (4) @(posedge clk_i);
    rchk(5'h0c, 32'h40);
  endtask : t_results
  task automatic t_pins();
    pin_dir_out_i <= 3'b011;
    port_data_i <= 3'b010;
    wb(5'h00, 1'b1, 32'hc2);
    wb(5'h04, 1'b1, 32'h82);
    repeat (4) @(posedge clk_i);
    `CHK(pin_o, 3'b011)
    `CHK(pin_oe_n_o, 3'b100)
    wb(5'h00, 1'b1, 32'he2);
    repeat (4) @(posedge clk_i);
    `CHK(pin_o[0], 1'b0)
  endtask : t_pins
  // every edge code on the third channel, flag bit 2
  task automatic t_events();
    for (int c = 0; c < 4; c++) begin
      plus_lvl[2] <= 8'h32;
      wb(5'h08, 1'b1, 32'h80 | (c << 3));
      repeat (5) @(posedge clk_i);
      rchk(5'h10, 32'(c == 3) << 2);
      wb(5'h10, 1'b1, 32'h4);
      plus_lvl[2] <= 8'hc8;
      repeat (6) @(posedge clk_i);
      rchk(5'h10, 32'(c[0]) << 2);
      wb(5'h10, 1'b1, 32'h4);
      plus_lvl[2] <= 8'h32;
      repeat (6) @(posedge clk_i);
      rchk(5'h10, 32'(c[1]) << 2);
      wb(5'h10, 1'b1, 32'h4);
    end
  endtask : t_events
  task automatic t_irq();
    wb(5'h14, 1'b1, 32'h4);
    wb(5'h18, 1'b1, 32'h4);
    rchk(5'h10, 32'h4);
    `CHK(irq_o, 1'b1)
    wb(5'h14, 1'b1, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(5'h14, 1'b1, 32'h4);
    wb(5'h10, 1'b1, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    rchk(5'h10, 32'h0);
  endtask : t_irq
  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {pin_dir_out_i, port_data_i, ref_lvl, shb_lvl, shd_lvl, bg_lvl} = '0;
    plus_lvl = '{default: 8'h00};
    pin_b_lvl = '{default: 8'h64};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_select();
    t_results();
    t_pins();
    t_events();
    t_irq();
    final_report();
  end
endmodule : ccl_top_tb_top
